/* File: hdl/chan_mode_pkg.sv */
// Constants, register map and mode codes for channel mode selection and activity LEDs.
// Assumes a 50 MHz APB clock and a one-word-per-register APB slave.
package chan_mode_pkg;

    typedef enum logic [3:0] {
        MODE_UART        = 4'h0,
        MODE_ASYNC_FIFO  = 4'h1,
        MODE_CPU_FIFO    = 4'h2,
        MODE_FAST_SERIAL = 4'h3,
        MODE_SYNC_FIFO   = 4'h4,
        MODE_ASYNC_BB    = 4'h5,
        MODE_SYNC_BB     = 4'h6,
        MODE_ENGINE      = 4'h7,
        MODE_HOST_BUS    = 4'h8,
        MODE_OFF         = 4'h9
    } chan_mode_e;

    typedef enum logic [1:0] {
        LD_RESET = 2'b00,
        LD_READ  = 2'b01,
        LD_DONE  = 2'b11
    } load_state_e;

    // Codes stored in the configuration memory for each channel.
    localparam logic [2:0] CFG_UART        = 3'h0;
    localparam logic [2:0] CFG_ASYNC_FIFO  = 3'h1;
    localparam logic [2:0] CFG_CPU_FIFO    = 3'h2;
    localparam logic [2:0] CFG_FAST_SERIAL = 3'h3;
    localparam logic [2:0] CFG_SYNC_FIFO   = 3'h4;

    // Bit-mode command values.
    localparam logic [7:0] CMD_BASE      = 8'h00;
    localparam logic [7:0] CMD_ASYNC_BB  = 8'h01;
    localparam logic [7:0] CMD_ENGINE    = 8'h02;
    localparam logic [7:0] CMD_SYNC_BB   = 8'h04;
    localparam logic [7:0] CMD_HOST_BUS  = 8'h08;
    localparam logic [7:0] CMD_SYNC_FIFO = 8'h40;

    // Register byte addresses.
    localparam logic [7:0] ADDR_MODE_CMD = 8'h00;
    localparam logic [7:0] ADDR_STATUS   = 8'h04;
    localparam logic [7:0] ADDR_EVENT    = 8'h08;
    localparam logic [7:0] ADDR_CONTROL  = 8'h0C;

    // Field positions.
    localparam int CMD_VAL_LSB     = 0;
    localparam int CMD_VAL_MSB     = 7;
    localparam int CMD_CHAN_BIT    = 8;
    localparam int ST_MODE_A_LSB   = 0;
    localparam int ST_MODE_B_LSB   = 4;
    localparam int ST_CFG_DONE_BIT = 8;
    localparam int ST_B_TRAFFIC    = 9;
    localparam int ST_LED_LSB      = 12;
    localparam int EV_REFUSED_BIT  = 0;
    localparam int EV_CFG_BAD_BIT  = 1;
    localparam int CTL_LED_EN_BIT  = 0;

    localparam logic [8:0] CMD_RESET    = 9'h000;
    localparam logic       LED_EN_RESET = 1'b1;

    // Pin defaults of an idle, unavailable second channel.
    localparam logic SPACE_FLAG_DEFAULT_N = 1'b0;
    localparam logic AVAIL_FLAG_DEFAULT_N = 1'b1;

    localparam int NUM_CHAN = 2;
    localparam int NUM_LED  = 4;

    // Stretch timing: counted in ticks of a microsecond enable.
    localparam int CLK_MHZ     = 50;
    localparam int TICK_NS     = 1000;
    localparam int TICK_CYCLES = (TICK_NS * CLK_MHZ + 999) / 1000;
    localparam int LED_HOLD_US = 50000;
    localparam int HOLD_W      = 16;
    localparam int TICK_W      = 6;

endpackage

/* File: hdl/led_if.sv */
// Trigger and lit level between the LED control and one stretcher.
// Assumes all ends sit on pclk.
`timescale 1ns/1ps
`default_nettype none
interface led_if;
    logic trig;
    logic tick;
    logic lit;
    modport ctl (output trig, output tick, input lit);
    modport shot (input trig, input tick, output lit);
endinterface
`default_nettype wire

/* File: hdl/activity_one_shot.sv */
// Retriggerable one-shot that stretches activity pulses for an indicator.
// Assumes trig and tick are single-cycle pulses on pclk.
`timescale 1ns/1ps
`default_nettype none
module activity_one_shot
    import chan_mode_pkg::*;
#(
    parameter logic [chan_mode_pkg::HOLD_W-1:0] HOLD_TICKS = 16'(chan_mode_pkg::LED_HOLD_US)
)
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Stretcher link
    led_if.shot port
);
    logic [HOLD_W-1:0] cnt_ff;

    // Reloading on every trigger keeps a steady stream lit without flicker.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cnt_ff <= '0;
        else if (port.trig)
            cnt_ff <= HOLD_TICKS;
        else if (port.tick && cnt_ff != '0)
            cnt_ff <= cnt_ff - 1'b1;
    end

    assign port.lit = (cnt_ff != '0);
endmodule
`default_nettype wire

/* File: hdl/channel_mode_select_activity_led.sv */
// Channel mode selection, configuration loading and UART activity LED drive.
// Assumes an APB master on pclk and a configuration memory reader that
// answers cfg_read_req with one cfg_valid pulse.
`timescale 1ns/1ps
`default_nettype none
module channel_mode_select_activity_led
    import chan_mode_pkg::*;
#(
    parameter logic [chan_mode_pkg::HOLD_W-1:0] LED_HOLD_TICKS = 16'(chan_mode_pkg::LED_HOLD_US)
)
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Configuration memory
    output logic cfg_read_req,
    input wire logic cfg_valid,
    input wire logic [2:0] cfg_code_a,
    input wire logic [2:0] cfg_code_b,
    // Channel data activity pulses, index 0 first channel
    input wire logic [chan_mode_pkg::NUM_CHAN-1:0] tx_activity,
    input wire logic [chan_mode_pkg::NUM_CHAN-1:0] rx_activity,
    // Indicator pins: 0 tx A, 1 rx A, 2 tx B, 3 rx B
    input wire logic [chan_mode_pkg::NUM_LED-1:0] led_in,
    output logic [chan_mode_pkg::NUM_LED-1:0] led_out,
    output logic [chan_mode_pkg::NUM_LED-1:0] led_oe_n,
    // Mode results
    output chan_mode_pkg::chan_mode_e mode_a,
    output chan_mode_pkg::chan_mode_e mode_b,
    output logic buf_merge_a,
    output logic chb_unavailable,
    // Second channel pin defaults
    output logic chb_force_defaults,
    output logic chb_data_pullup_en,
    output logic chb_strobe_input,
    output logic chb_tx_space_flag_n,
    output logic chb_rx_available_flag_n
);
    load_state_e ld_ff;
    chan_mode_e mode_ff [NUM_CHAN];
    chan_mode_e base_ff [NUM_CHAN];
    logic cfg_done_ff;
    logic [8:0] cmd_ff;
    logic refused_ff;
    logic cfg_bad_ff;
    logic led_en_ff;
    logic b_traffic_ff;
    logic b_defaults_ff;
    logic [31:0] prdata_ff;
    logic [TICK_W-1:0] tick_cnt_ff;
    logic tick;
    logic [NUM_LED-1:0] led_lit;
    logic [NUM_LED-1:0] led_act;

    logic setup_ph;
    logic wr_acc;
    logic [7:0] reg_addr;
    logic addr_ok;
    logic cmd_wr;
    logic ev_wr;
    logic [7:0] cmd_val;
    logic cmd_chan;
    logic cmd_reject;

    // Maps a stored configuration code to a base mode; bad codes fall back to UART.
    function automatic chan_mode_e cfg_to_mode(input logic [2:0] code);
        chan_mode_e m;
        m = MODE_UART;
        unique case (code)
            CFG_UART:        m = MODE_UART;
            CFG_ASYNC_FIFO:  m = MODE_ASYNC_FIFO;
            CFG_CPU_FIFO:    m = MODE_CPU_FIFO;
            CFG_FAST_SERIAL: m = MODE_FAST_SERIAL;
            CFG_SYNC_FIFO:   m = MODE_SYNC_FIFO;
            default:         m = MODE_UART;
        endcase
        return m;
    endfunction

    function automatic logic cfg_code_ok(input logic [2:0] code);
        return code <= CFG_SYNC_FIFO;
    endfunction

    // APB decode. Zero wait states: read data is captured in the setup cycle.
    assign reg_addr = paddr[7:0];
    assign addr_ok = (paddr[31:8] == '0) && (reg_addr == ADDR_MODE_CMD ||
        reg_addr == ADDR_STATUS || reg_addr == ADDR_EVENT || reg_addr == ADDR_CONTROL);
    assign setup_ph = psel && !penable;
    assign pready = psel && penable;
    assign pslverr = psel && penable && !addr_ok;
    assign wr_acc = psel && penable && pwrite && addr_ok;
    assign cmd_wr = wr_acc && reg_addr == ADDR_MODE_CMD;
    assign ev_wr = wr_acc && reg_addr == ADDR_EVENT;
    assign cmd_val = pwdata[CMD_VAL_MSB:CMD_VAL_LSB];
    assign cmd_chan = pwdata[CMD_CHAN_BIT];
    assign prdata = prdata_ff;

    // Sync FIFO is accepted only on the first channel, only while both
    // channels sit in async FIFO set up by the configuration memory.
    always_comb
    begin
        cmd_reject = 1'b0;
        if (!cfg_done_ff)
            cmd_reject = 1'b1;
        else if (cmd_chan && mode_ff[1] == MODE_OFF)
            cmd_reject = 1'b1;
        else if (cmd_val == CMD_SYNC_FIFO)
            cmd_reject = cmd_chan || base_ff[0] != MODE_ASYNC_FIFO ||
                base_ff[1] != MODE_ASYNC_FIFO || mode_ff[0] != MODE_ASYNC_FIFO ||
                mode_ff[1] != MODE_ASYNC_FIFO;
        else if (cmd_val != CMD_BASE && cmd_val != CMD_ASYNC_BB &&
                 cmd_val != CMD_SYNC_BB && cmd_val != CMD_ENGINE &&
                 cmd_val != CMD_HOST_BUS)
            cmd_reject = 1'b1;
    end

    // Configuration load sequencer.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ld_ff <= LD_RESET;
        else
        begin
            unique case (ld_ff)
                LD_RESET: ld_ff <= LD_READ;
                LD_READ:  if (cfg_valid) ld_ff <= LD_DONE;
                LD_DONE:  ld_ff <= LD_DONE;
                default:  ld_ff <= LD_RESET;
            endcase
        end
    end

    assign cfg_read_req = (ld_ff == LD_READ);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cfg_done_ff <= 1'b0;
        else if (ld_ff == LD_READ && cfg_valid)
            cfg_done_ff <= 1'b1;
    end

    // Base modes come from the stored configuration; a stored sync FIFO
    // on the first channel retires the second.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            base_ff[0] <= MODE_UART;
            base_ff[1] <= MODE_UART;
        end
        else if (ld_ff == LD_READ && cfg_valid)
        begin
            base_ff[0] <= cfg_to_mode(cfg_code_a);
            if (cfg_to_mode(cfg_code_a) == MODE_SYNC_FIFO)
                base_ff[1] <= MODE_OFF;
            else if (cfg_to_mode(cfg_code_b) == MODE_SYNC_FIFO)
                base_ff[1] <= MODE_ASYNC_FIFO;
            else
                base_ff[1] <= cfg_to_mode(cfg_code_b);
        end
    end

    // Active modes: loaded from the base, then changed by bit-mode commands.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mode_ff[0] <= MODE_UART;
            mode_ff[1] <= MODE_UART;
        end
        else if (ld_ff == LD_READ && cfg_valid)
        begin
            mode_ff[0] <= cfg_to_mode(cfg_code_a);
            if (cfg_to_mode(cfg_code_a) == MODE_SYNC_FIFO)
                mode_ff[1] <= MODE_OFF;
            else if (cfg_to_mode(cfg_code_b) == MODE_SYNC_FIFO)
                mode_ff[1] <= MODE_ASYNC_FIFO;
            else
                mode_ff[1] <= cfg_to_mode(cfg_code_b);
        end
        else if (cmd_wr && !cmd_reject)
        begin
            unique case (cmd_val)
                CMD_ASYNC_BB: mode_ff[cmd_chan] <= MODE_ASYNC_BB;
                CMD_SYNC_BB:  mode_ff[cmd_chan] <= MODE_SYNC_BB;
                CMD_ENGINE:   mode_ff[cmd_chan] <= MODE_ENGINE;
                CMD_HOST_BUS: mode_ff[cmd_chan] <= MODE_HOST_BUS;
                CMD_SYNC_FIFO:
                begin
                    mode_ff[0] <= MODE_SYNC_FIFO;
                    mode_ff[1] <= MODE_OFF;
                end
                default: mode_ff[cmd_chan] <= base_ff[cmd_chan];
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cmd_ff <= CMD_RESET;
        else if (cmd_wr)
            cmd_ff <= pwdata[CMD_CHAN_BIT:CMD_VAL_LSB];
    end

    // Sticky events; a new event in the clearing cycle wins.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            refused_ff <= 1'b0;
        else if (cmd_wr && cmd_reject)
            refused_ff <= 1'b1;
        else if (ev_wr && pwdata[EV_REFUSED_BIT])
            refused_ff <= 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cfg_bad_ff <= 1'b0;
        else if (ld_ff == LD_READ && cfg_valid &&
                 !(cfg_code_ok(cfg_code_a) && cfg_code_ok(cfg_code_b)))
            cfg_bad_ff <= 1'b1;
        else if (ev_wr && pwdata[EV_CFG_BAD_BIT])
            cfg_bad_ff <= 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            led_en_ff <= LED_EN_RESET;
        else if (wr_acc && reg_addr == ADDR_CONTROL)
            led_en_ff <= pwdata[CTL_LED_EN_BIT];
    end

    // Any traffic on the second channel before it is retired is remembered.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            b_traffic_ff <= 1'b0;
        else if (mode_ff[1] != MODE_OFF && (tx_activity[1] || rx_activity[1]))
            b_traffic_ff <= 1'b1;
    end

    // Defaults are decided once, at the moment the second channel is retired.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            b_defaults_ff <= 1'b0;
        else if (mode_ff[1] != MODE_OFF)
            b_defaults_ff <= 1'b0;
        else if (!b_defaults_ff && !b_traffic_ff)
            b_defaults_ff <= 1'b1;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_ff <= '0;
        else if (setup_ph)
        begin
            prdata_ff <= '0;
            unique case (reg_addr)
                ADDR_MODE_CMD: prdata_ff[CMD_CHAN_BIT:CMD_VAL_LSB] <= cmd_ff;
                ADDR_STATUS:
                begin
                    prdata_ff[ST_MODE_A_LSB +: 4] <= mode_ff[0];
                    prdata_ff[ST_MODE_B_LSB +: 4] <= mode_ff[1];
                    prdata_ff[ST_CFG_DONE_BIT] <= cfg_done_ff;
                    prdata_ff[ST_B_TRAFFIC] <= b_traffic_ff;
                    prdata_ff[ST_LED_LSB +: NUM_LED] <= ~led_in;
                end
                ADDR_EVENT:
                begin
                    prdata_ff[EV_REFUSED_BIT] <= refused_ff;
                    prdata_ff[EV_CFG_BAD_BIT] <= cfg_bad_ff;
                end
                ADDR_CONTROL: prdata_ff[CTL_LED_EN_BIT] <= led_en_ff;
                default: prdata_ff <= '0;
            endcase
        end
    end

    // Microsecond enable for the stretchers.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            tick_cnt_ff <= '0;
        else if (tick)
            tick_cnt_ff <= '0;
        else
            tick_cnt_ff <= tick_cnt_ff + 1'b1;
    end

    assign tick = (tick_cnt_ff == TICK_W'(TICK_CYCLES - 1));

    // Activity only counts while the owning channel is a UART.
    assign led_act = {rx_activity[1], tx_activity[1], rx_activity[0], tx_activity[0]};

    generate
        for (genvar i = 0; i < NUM_LED; i++)
        begin : g_led
            led_if lnk ();
            assign lnk.trig = led_act[i] && mode_ff[i / 2] == MODE_UART;
            assign lnk.tick = tick;
            assign led_lit[i] = lnk.lit && mode_ff[i / 2] == MODE_UART && led_en_ff;
            activity_one_shot #(
                .HOLD_TICKS(LED_HOLD_TICKS)
            ) u_shot (
                .pclk(pclk),
                .presetn(presetn),
                .port(lnk.shot)
            );
        end
    endgenerate

    // Open-drain: only ever pulls low, floats otherwise.
    assign led_out = '0;
    assign led_oe_n = ~led_lit;

    assign mode_a = mode_ff[0];
    assign mode_b = mode_ff[1];
    assign buf_merge_a = (mode_ff[0] == MODE_SYNC_FIFO);
    assign chb_unavailable = (mode_ff[1] == MODE_OFF);
    assign chb_force_defaults = b_defaults_ff;
    assign chb_data_pullup_en = b_defaults_ff;
    assign chb_strobe_input = b_defaults_ff;
    assign chb_tx_space_flag_n = b_defaults_ff ? SPACE_FLAG_DEFAULT_N : ~SPACE_FLAG_DEFAULT_N;
    assign chb_rx_available_flag_n = b_defaults_ff ? AVAIL_FLAG_DEFAULT_N : ~AVAIL_FLAG_DEFAULT_N;
endmodule
`default_nettype wire

/* File: test/chan_mode_sva.sv */
// Checker for the channel mode and indicator block; sees top-level ports only.
// Assumes a single clock, pclk, and presetn as the asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
module chan_mode_sva
    import chan_mode_pkg::*;
#(
    parameter logic [chan_mode_pkg::HOLD_W-1:0] LED_HOLD_TICKS = 16'h0003
)
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    // Configuration and activity
    input wire logic cfg_read_req,
    input wire logic cfg_valid,
    input wire logic [chan_mode_pkg::NUM_CHAN-1:0] tx_activity,
    // Results
    input wire logic [chan_mode_pkg::NUM_LED-1:0] led_out,
    input wire logic [chan_mode_pkg::NUM_LED-1:0] led_oe_n,
    input wire chan_mode_pkg::chan_mode_e mode_a,
    input wire chan_mode_pkg::chan_mode_e mode_b,
    input wire logic buf_merge_a,
    input wire logic chb_unavailable,
    input wire logic chb_force_defaults,
    input wire logic chb_data_pullup_en,
    input wire logic chb_strobe_input,
    input wire logic chb_tx_space_flag_n,
    input wire logic chb_rx_available_flag_n
);
    localparam int HOLD_CYC = int'(LED_HOLD_TICKS) * TICK_CYCLES;
    int since_tx_ff;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Cycles since the last first-channel transmit pulse, saturating.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            since_tx_ff <= 1000000;
        else if (tx_activity[0])
            since_tx_ff <= 0;
        else if (since_tx_ff < 1000000)
            since_tx_ff <= since_tx_ff + 1;
    end
    property p_led_low;
        led_out == '0;
    endproperty
    a_led_low: assert property (p_led_low) else $error("indicator driven high");
    property p_lit_uart;
        !led_oe_n[0] |-> mode_a == MODE_UART;
    endproperty
    a_lit_uart: assert property (p_lit_uart) else $error("lit outside serial mode");
    property p_light_cause;
        $fell(led_oe_n[0]) |-> $past(tx_activity[0]);
    endproperty
    a_light_cause: assert property (p_light_cause) else $error("lit without pulse");
    property p_release;
        $rose(led_oe_n[0]) |-> since_tx_ff >= HOLD_CYC - TICK_CYCLES - 2;
    endproperty
    a_release: assert property (p_release) else $error("indicator released early");
    property p_lit_bound;
        !led_oe_n[0] |-> since_tx_ff <= HOLD_CYC + 2;
    endproperty
    a_lit_bound: assert property (p_lit_bound) else $error("indicator held too long");
    property p_apb;
        psel && penable |-> pready && (pslverr == (paddr[31:8] != 24'h0 || paddr[1:0] != 2'h0
            || paddr[7:0] > 8'h0C));
    endproperty
    a_apb: assert property (p_apb) else $error("bus answer wrong");
    property p_merge;
        buf_merge_a == (mode_a == MODE_SYNC_FIFO) && chb_unavailable == (mode_b == MODE_OFF);
    endproperty
    a_merge: assert property (p_merge) else $error("buffer merge mismatch");
    property p_cfg_once;
        cfg_read_req && cfg_valid |=> !cfg_read_req [*8];
    endproperty
    a_cfg_once: assert property (p_cfg_once) else $error("second load request");
    property p_defaults;
        chb_force_defaults |-> chb_data_pullup_en && chb_strobe_input && chb_unavailable
            && !chb_tx_space_flag_n && chb_rx_available_flag_n;
    endproperty
    a_defaults: assert property (p_defaults) else $error("pin defaults wrong");
    c_lit: cover property ($fell(led_oe_n[0]));
    c_merge: cover property ($rose(buf_merge_a));
    c_defaults: cover property ($rose(chb_force_defaults));
endmodule
`default_nettype wire

/* File: test/cfg_mem_model.sv */
// Configuration memory model: answers each read request with one valid pulse.
// Assumes requests on pclk; the stored codes are set by the bench.
`timescale 1ns/1ps
`default_nettype none
module cfg_mem_model
#(
    parameter int DLY = 4
)
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Memory side
    input wire logic cfg_read_req,
    output logic cfg_valid,
    output logic [2:0] cfg_code_a,
    output logic [2:0] cfg_code_b,
    // Stored codes
    input wire logic [2:0] set_a,
    input wire logic [2:0] set_b
);
    int wait_ff;
    // Outside the pulse the lines carry the inverse, so a late sample shows.
    assign cfg_code_a = cfg_valid ? set_a : ~set_a;
    assign cfg_code_b = cfg_valid ? set_b : ~set_b;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wait_ff <= 0;
            cfg_valid <= 1'b0;
        end
        else
        begin
            cfg_valid <= cfg_read_req && !cfg_valid && wait_ff == DLY;
            wait_ff <= (cfg_read_req && !cfg_valid) ? wait_ff + 1 : 0;
        end
    end
endmodule
`default_nettype wire

/* File: test/test_channel_mode_select_activity_led.sv */
// Self-checking bench for channel mode selection and the activity indicators.
// Assumes the memory model and the checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module test_channel_mode_select_activity_led;
    import chan_mode_pkg::*;
    localparam logic [15:0] HOLD = 16'h0003;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, cfg_read_req, cfg_valid, er;
    logic [2:0] cfg_code_a, cfg_code_b, set_a = 3'h0, set_b = 3'h0;
    logic [1:0] tx_activity = 2'h0, rx_activity = 2'h0;
    logic [3:0] led_in, led_out, led_oe_n;
    chan_mode_e mode_a, mode_b;
    logic buf_merge_a, chb_unavailable, chb_force_defaults, chb_data_pullup_en;
    logic chb_strobe_input, chb_tx_space_flag_n, chb_rx_available_flag_n;
    int miscompares = 0;
    int num_checks = 0;
    always #10 pclk = ~pclk;
    // A released pin floats up through its LED to the supply.
    assign led_in = led_oe_n | led_out;
    channel_mode_select_activity_led #(.LED_HOLD_TICKS(HOLD)) i_dut (.pclk, .presetn, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .cfg_read_req,
        .cfg_valid, .cfg_code_a, .cfg_code_b, .tx_activity, .rx_activity, .led_in, .led_out,
        .led_oe_n, .mode_a, .mode_b, .buf_merge_a, .chb_unavailable, .chb_force_defaults,
        .chb_data_pullup_en, .chb_strobe_input, .chb_tx_space_flag_n,
        .chb_rx_available_flag_n);
    cfg_mem_model #(.DLY(4)) i_mem (.pclk, .presetn, .cfg_read_req, .cfg_valid, .cfg_code_a,
        .cfg_code_b, .set_a, .set_b);
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_mode(input chan_mode_e ea, input chan_mode_e eb);
        check(32'(mode_a), 32'(ea));
        check(32'(mode_b), 32'(eb));
    endtask
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            check(32'h0, 32'h1);
            finish_test();
        end
        @(negedge pclk);
    endtask
    task automatic rd_chk(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check(rd & m, e);
    endtask
    task automatic pulse(input logic [3:0] m);
        @(posedge pclk);
        tx_activity <= {m[2], m[0]};
        rx_activity <= {m[3], m[1]};
        @(posedge pclk);
        tx_activity <= 2'h0;
        rx_activity <= 2'h0;
    endtask
    task automatic wait_lit(input int n, input logic [3:0] e);
        repeat (n) @(posedge pclk);
        @(negedge pclk);
        check(32'(led_oe_n), 32'(e));
    endtask
    task automatic do_reset(input logic [2:0] a, input logic [2:0] b);
        int n;
        @(posedge pclk);
        set_a <= a;
        set_b <= b;
        presetn <= 1'b0;
        repeat (16) @(posedge pclk);
        chk_mode(MODE_UART, MODE_UART);
        check(32'(led_oe_n), 32'hF);
        presetn <= 1'b1;
        n = 0;
        do
        begin
            @(negedge pclk);
            n++;
        end
        while ((n < 3 || cfg_read_req !== 1'b0) && n < 40);
        check(32'(n < 40), 32'h1);
        if (n >= 40)
            finish_test();
        rd_chk(ADDR_STATUS, 32'h100, 32'h100);
    endtask
    task automatic t_leds();
        do_reset(CFG_UART, CFG_UART);
        rd_chk(ADDR_CONTROL, 32'h1, 32'h1);
        for (int i = 0; i < 4; i++)
        begin
            pulse(4'h1 << i);
            rd_chk(ADDR_STATUS, 32'hF000, 32'h1000 << i);
            wait_lit(80, ~(4'h1 << i));
            pulse(4'h1 << i);
            wait_lit(90, ~(4'h1 << i));
            wait_lit(70, 4'hF);
        end
        apb(1'b1, ADDR_CONTROL, 32'h0);
        pulse(4'h1);
        wait_lit(3, 4'hF);
        repeat (200) @(posedge pclk);
        apb(1'b1, ADDR_CONTROL, 32'h1);
        rd_chk(ADDR_CONTROL, 32'h1, 32'h1);
    endtask
    task automatic t_cmds();
        logic [7:0] vals[4] = '{CMD_ASYNC_BB, CMD_SYNC_BB, CMD_ENGINE, CMD_HOST_BUS};
        chan_mode_e ms[4] = '{MODE_ASYNC_BB, MODE_SYNC_BB, MODE_ENGINE, MODE_HOST_BUS};
        for (int c = 0; c < 2; c++)
            for (int k = 0; k < 4; k++)
            begin
                apb(1'b1, ADDR_MODE_CMD, {23'h0, c[0], vals[k]});
                chk_mode(c ? MODE_UART : ms[k], c ? ms[k] : MODE_UART);
                apb(1'b1, ADDR_MODE_CMD, {23'h0, c[0], CMD_BASE});
                chk_mode(MODE_UART, MODE_UART);
            end
        apb(1'b1, ADDR_MODE_CMD, 32'h1);
        pulse(4'h1);
        wait_lit(3, 4'hF);
        apb(1'b1, ADDR_MODE_CMD, 32'h0);
        apb(1'b1, ADDR_MODE_CMD, 32'h10);
        chk_mode(MODE_UART, MODE_UART);
        rd_chk(ADDR_EVENT, 32'h1, 32'h1);
        apb(1'b1, ADDR_EVENT, 32'h1);
        rd_chk(ADDR_EVENT, 32'h1, 32'h0);
        apb(1'b0, 32'h10, 32'h0);
        check({31'h0, er}, 32'h1);
        check(rd, 32'h0);
    endtask
    task automatic t_sync(input logic traffic);
        // Both channels async FIFO and B pins undriven before the request
        do_reset(CFG_ASYNC_FIFO, CFG_ASYNC_FIFO);
        chk_mode(MODE_ASYNC_FIFO, MODE_ASYNC_FIFO);
        if (traffic)
            pulse(4'h8);
        apb(1'b1, ADDR_MODE_CMD, 32'h40);
        chk_mode(MODE_SYNC_FIFO, MODE_OFF);
        check({30'h0, buf_merge_a, chb_unavailable}, 32'h3);
        @(negedge pclk);
        check({31'h0, chb_force_defaults}, {31'h0, !traffic});
        check({28'h0, chb_data_pullup_en, chb_strobe_input, chb_tx_space_flag_n,
            chb_rx_available_flag_n}, traffic ? 32'h2 : 32'hD);
        apb(1'b1, ADDR_MODE_CMD, 32'h101);
        chk_mode(MODE_SYNC_FIFO, MODE_OFF);
        rd_chk(ADDR_EVENT, 32'h1, 32'h1);
    endtask
    task automatic t_cfg();
        logic [2:0] ca[3] = '{CFG_CPU_FIFO, 3'h5, CFG_SYNC_FIFO};
        logic [2:0] cb[3] = '{CFG_FAST_SERIAL, CFG_SYNC_FIFO, CFG_UART};
        chan_mode_e ea[3] = '{MODE_CPU_FIFO, MODE_UART, MODE_SYNC_FIFO};
        chan_mode_e eb[3] = '{MODE_FAST_SERIAL, MODE_ASYNC_FIFO, MODE_OFF};
        for (int k = 0; k < 3; k++)
        begin
            do_reset(ca[k], cb[k]);
            chk_mode(ea[k], eb[k]);
            rd_chk(ADDR_EVENT, 32'h2, (k == 1) ? 32'h2 : 32'h0);
            if (k < 2)
            begin
                apb(1'b1, ADDR_MODE_CMD, 32'h40);
                chk_mode(ea[k], eb[k]);
            end
        end
    endtask
    initial
    begin
        t_leds();
        t_cmds();
        t_sync(1'b0);
        t_sync(1'b1);
        t_cfg();
        finish_test();
    end
endmodule
bind channel_mode_select_activity_led chan_mode_sva #(.LED_HOLD_TICKS(LED_HOLD_TICKS)) i_sva (
    .pclk, .presetn, .psel, .penable, .paddr, .pready, .pslverr, .cfg_read_req, .cfg_valid,
    .tx_activity, .led_out, .led_oe_n, .mode_a, .mode_b, .buf_merge_a, .chb_unavailable,
    .chb_force_defaults, .chb_data_pullup_en, .chb_strobe_input, .chb_tx_space_flag_n,
    .chb_rx_available_flag_n);
`default_nettype wire
